/* common/sched_ptr_pkg.sv */
package sched_ptr_pkg;
  // register offsets from the memory base of the host controller function
  localparam logic [7:0] OFS_PERIODIC_FRAME_LIST_START = 8'h34;
  localparam logic [7:0] OFS_ASYNC_LIST_NEXT_HEAD = 8'h38;
  localparam logic [7:0] OFS_PORT_ROUTING_CONFIG_FLAG = 8'h60;
  // reset values
  localparam logic [31:0] RST_PERIODIC_FRAME_LIST_START = 32'h0000_0000;
  localparam logic [31:0] RST_ASYNC_LIST_NEXT_HEAD = 32'h0000_0000;
  localparam logic [31:0] RST_PORT_ROUTING_CONFIG_FLAG = 32'h0000_0000;
  // field layout
  localparam int PTR_FIELD_LSB = 12;
  localparam int ASYNC_STORED_LSB = 5;
  localparam int CFG_FLAG_BIT = 0;
  localparam logic [31:0] PERIODIC_WRITE_MASK = 32'hffff_f000;
  localparam logic [31:0] ASYNC_WRITE_MASK = 32'hffff_ffe0;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h0000_0001;
  // frame list index taken from counter bits N..3
  localparam int COUNTER_WIDTH = 14;
  localparam int INDEX_LSB = 3;
  localparam int INDEX_WIDTH = 10;
  localparam int ENTRY_BYTE_SHIFT = 2;
  typedef enum logic [1:0] {
    LIST_1024 = 2'h0,
    LIST_512 = 2'h1,
    LIST_256 = 2'h2,
    LIST_RSVD = 2'h3
  } frame_list_size_t;
endpackage

/* rtl/periodic_entry_addr.sv */
`timescale 1ns/1ps
module periodic_entry_addr (
  // list start and counter
  input wire logic [19:0] i_start_bits,
  input wire logic [sched_ptr_pkg::COUNTER_WIDTH-1:0] i_counter,
  input wire sched_ptr_pkg::frame_list_size_t i_size,
  // formed low address word
  output logic [31:0] o_addr
);
  import sched_ptr_pkg::*;

  logic [INDEX_WIDTH-1:0] index;

  // reserved size code falls back to the full list so the index never leaves the page
  always_comb begin
    unique case (i_size)
      LIST_512: index = {1'b0, i_counter[11:INDEX_LSB]}; // [RULE15]
      LIST_256: index = {2'b00, i_counter[10:INDEX_LSB]}; // [RULE15]
      default: index = i_counter[12:INDEX_LSB]; // [RULE15]
    endcase
  end

  // one word per entry, page bits straight from the stored pointer
  assign o_addr = {i_start_bits, index, {ENTRY_BYTE_SHIFT{1'b0}}}; // [RULE4] [RULE16] [RULE3]
endmodule

/* rtl/usb2_schedule_pointer_regs.sv */
`timescale 1ns/1ps
// Behaviour
// RULE1: with wide-address capability set, upper 32 fetch address bits come from segment register.
// RULE2: software writes the periodic list start before starting the schedule.
// RULE3: periodic list is 4 kB aligned; pointer supplies no low address bits.
// RULE4: entry address combines stored list start with the microframe counter.
// RULE5: periodic start field is bits 31..12; bits 11..0 reserved, reset zero.
// RULE6: async head register is 32 bits; bits 4..0 always read zero.
// RULE7: async queue head is 32-byte aligned, and the device relies on it.
// RULE8: async head field is bits 31..5; bits 4..0 reserved, reset zero.
// RULE9: software loads only queue head addresses into the async head field.
// RULE10: software writes reserved bits with zero.
// RULE11: config flag register holds one read-write bit 0, reset zero, rest reserved.
// RULE12: registers decode at offsets 34h, 38h, 60h from the function memory base.
// RULE13: flag 1 routes every port here; flag 0 routes to companion controller.
// RULE14: software sets the config flag as its final configuration step.
// RULE15: frame list index is counter bits N..3, N=12, 11, 10 by size.
// RULE16: entry address is start bits, index bits and two zero low bits.
module usb2_schedule_pointer_regs #(
  parameter int NUM_PORTS = 2
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // register access within the function memory window
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [3:0] I_REG_BE,
  input wire logic [31:0] I_REG_WDATA,
  output logic [31:0] O_REG_RDATA,
  output logic O_REG_ACK,
  // schedule context from the rest of the controller
  input wire logic I_WIDE_ADDRESS_CAPABILITY,
  input wire logic [31:0] I_UPPER_ADDRESS_SEGMENT,
  input wire logic [sched_ptr_pkg::COUNTER_WIDTH-1:0] I_MICROFRAME_COUNTER,
  input wire sched_ptr_pkg::frame_list_size_t I_FRAME_LIST_SIZE_SELECT,
  // fetch addresses and port routing
  output logic [63:0] O_PERIODIC_ENTRY_ADDR,
  output logic [63:0] O_ASYNC_HEAD_ADDR,
  output logic O_PORT_OWNER_SELECT_FLAG,
  output logic [NUM_PORTS-1:0] O_PORT_ROUTE_TO_HS
);
  import sched_ptr_pkg::*;

  // stored registers
  logic [31:0] periodic_frame_list_start;
  logic [31:0] async_list_next_head;
  logic [31:0] port_routing_config_flag;

  // bus decode and write merge
  logic hit_periodic;
  logic hit_async;
  logic hit_cfg;
  logic write_periodic;
  logic write_async;
  logic write_cfg;
  logic access_any;
  logic [31:0] byte_mask;
  logic [31:0] next_periodic;
  logic [31:0] next_async;
  logic [31:0] next_cfg;

  // read values
  logic [31:0] periodic_read_value;
  logic [31:0] async_read_value;
  logic [31:0] cfg_read_value;
  logic [31:0] next_rdata;

  // fetch address parts
  logic [19:0] start_bits;
  logic [31:0] entry_low;
  logic [31:0] async_low;
  logic [31:0] upper_bits;
  logic flag_now;

  // lanes not enabled keep their old bytes; bits outside keep are never stored
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_value,
    input logic [31:0] new_value,
    input logic [31:0] lanes,
    input logic [31:0] keep
  );
    merge_lanes = ((old_value & ~lanes) | (new_value & lanes)) & keep;
  endfunction

  assign hit_periodic = (I_REG_ADDR == OFS_PERIODIC_FRAME_LIST_START); // [RULE12]
  assign hit_async = (I_REG_ADDR == OFS_ASYNC_LIST_NEXT_HEAD); // [RULE12]
  assign hit_cfg = (I_REG_ADDR == OFS_PORT_ROUTING_CONFIG_FLAG); // [RULE12]

  assign write_periodic = I_REG_WR && hit_periodic;
  assign write_async = I_REG_WR && hit_async;
  // the flag lives in lane 0 alone, so a write without that lane leaves it as it is
  assign write_cfg = I_REG_WR && hit_cfg && I_REG_BE[0]; // [RULE11]
  assign access_any = I_REG_WR || I_REG_RD;

  // byte lanes let software update part of a pointer without a read-modify-write
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign byte_mask[b*8 +: 8] = {8{I_REG_BE[b]}};
    end
  endgenerate

  // low bits are dropped before storing, so stray writes cannot misalign a list
  assign next_periodic = merge_lanes(periodic_frame_list_start, I_REG_WDATA, byte_mask,
    PERIODIC_WRITE_MASK); // [RULE5] [RULE3]
  assign next_async = merge_lanes(async_list_next_head, I_REG_WDATA, byte_mask,
    ASYNC_WRITE_MASK); // [RULE6] [RULE7]
  assign next_cfg = I_REG_WDATA & CFG_WRITE_MASK; // [RULE11]

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      periodic_frame_list_start <= RST_PERIODIC_FRAME_LIST_START; // [RULE5]
    end else if (write_periodic) begin
      periodic_frame_list_start <= next_periodic; // [RULE5]
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      async_list_next_head <= RST_ASYNC_LIST_NEXT_HEAD; // [RULE8]
    end else if (write_async) begin
      async_list_next_head <= next_async; // [RULE8]
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      port_routing_config_flag <= RST_PORT_ROUTING_CONFIG_FLAG; // [RULE11]
    end else if (write_cfg) begin
      port_routing_config_flag <= next_cfg; // [RULE11]
    end
  end

  assign periodic_read_value = periodic_frame_list_start & PERIODIC_WRITE_MASK; // [RULE5]
  assign async_read_value = async_list_next_head & ASYNC_WRITE_MASK; // [RULE6]
  assign cfg_read_value = port_routing_config_flag & CFG_WRITE_MASK; // [RULE11]

  // read mux; unmapped offsets return zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (I_REG_ADDR)
      OFS_PERIODIC_FRAME_LIST_START: begin
        next_rdata = periodic_read_value; // [RULE12]
      end
      OFS_ASYNC_LIST_NEXT_HEAD: begin
        next_rdata = async_read_value; // [RULE12]
      end
      OFS_PORT_ROUTING_CONFIG_FLAG: begin
        next_rdata = cfg_read_value; // [RULE12]
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_REG_RDATA <= 32'h0000_0000;
    end else if (I_REG_RD) begin
      O_REG_RDATA <= next_rdata;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_REG_ACK <= 1'b0;
    end else if (access_any) begin
      O_REG_ACK <= 1'b1;
    end else begin
      O_REG_ACK <= 1'b0;
    end
  end

  assign start_bits = periodic_frame_list_start[31:PTR_FIELD_LSB]; // [RULE3]

  periodic_entry_addr u_entry (
    .i_start_bits(start_bits),
    .i_counter(I_MICROFRAME_COUNTER),
    .i_size(I_FRAME_LIST_SIZE_SELECT),
    .o_addr(entry_low)
  );

  // without the capability the upper half is forced to zero
  assign upper_bits = I_WIDE_ADDRESS_CAPABILITY ? I_UPPER_ADDRESS_SEGMENT : 32'h0000_0000; // [RULE1]
  assign async_low = async_read_value; // [RULE7]

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_PERIODIC_ENTRY_ADDR <= 64'h0;
    end else begin
      O_PERIODIC_ENTRY_ADDR <= {upper_bits, entry_low}; // [RULE1] [RULE4]
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_ASYNC_HEAD_ADDR <= 64'h0;
    end else begin
      O_ASYNC_HEAD_ADDR <= {upper_bits, async_low}; // [RULE1] [RULE7]
    end
  end

  // the owner flag is shown at once; routing follows it one cycle later
  assign flag_now = port_routing_config_flag[CFG_FLAG_BIT];
  assign O_PORT_OWNER_SELECT_FLAG = flag_now; // [RULE11]

  // every port follows the one flag; the companion takes the port when it is clear
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_route
      always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
          O_PORT_ROUTE_TO_HS[p] <= 1'b0;
        end else begin
          O_PORT_ROUTE_TO_HS[p] <= flag_now; // [RULE13]
        end
      end
    end
  endgenerate
endmodule

/* sim/sched_ptr_properties.sv */
`timescale 1ns/1ps
module sched_ptr_checker import sched_ptr_pkg::*; #(parameter int NUM_PORTS = 2) (
  // clock, reset and register access
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [31:0] O_REG_RDATA,
  input wire logic O_REG_ACK,
  // schedule context and outputs
  input wire logic I_WIDE_ADDRESS_CAPABILITY,
  input wire logic [31:0] I_UPPER_ADDRESS_SEGMENT,
  input wire logic [sched_ptr_pkg::COUNTER_WIDTH-1:0] I_MICROFRAME_COUNTER,
  input wire sched_ptr_pkg::frame_list_size_t I_FRAME_LIST_SIZE_SELECT,
  input wire logic [63:0] O_PERIODIC_ENTRY_ADDR,
  input wire logic [63:0] O_ASYNC_HEAD_ADDR,
  input wire logic O_PORT_OWNER_SELECT_FLAG,
  input wire logic [NUM_PORTS-1:0] O_PORT_ROUTE_TO_HS
);
  import sched_ptr_pkg::*;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  ack_after_access_a: assert property (
    (I_REG_WR || I_REG_RD) |=> O_REG_ACK) else $error("no ack after access");
  ack_only_access_a: assert property (
    !(I_REG_WR || I_REG_RD) |=> !O_REG_ACK) else $error("ack without access");
  periodic_low_zero_a: assert property (
    I_REG_RD && I_REG_ADDR == OFS_PERIODIC_FRAME_LIST_START |=> O_REG_RDATA[11:0] == 12'h000)
    else $error("periodic low bits read nonzero");
  async_low_zero_a: assert property (
    I_REG_RD && I_REG_ADDR == OFS_ASYNC_LIST_NEXT_HEAD |=> O_REG_RDATA[4:0] == 5'h00)
    else $error("async low bits read nonzero");
  flag_single_bit_a: assert property (
    I_REG_RD && I_REG_ADDR == OFS_PORT_ROUTING_CONFIG_FLAG |=> O_REG_RDATA[31:1] == 31'h0)
    else $error("flag upper bits read nonzero");
  route_follows_flag_a: assert property (
    O_PORT_ROUTE_TO_HS == {NUM_PORTS{$past(O_PORT_OWNER_SELECT_FLAG)}})
    else $error("routing differs from flag");
  // the reset cycle is excluded: outputs are cleared there, not formed from inputs
  upper_segment_a: assert property (
    !$past(I_RST) |-> O_ASYNC_HEAD_ADDR[63:32] ==
    ($past(I_WIDE_ADDRESS_CAPABILITY) ? $past(I_UPPER_ADDRESS_SEGMENT) : 32'h0))
    else $error("upper fetch address wrong");
  index_bits_a: assert property (
    !$past(I_RST) && $past(I_FRAME_LIST_SIZE_SELECT) == LIST_1024 |->
    O_PERIODIC_ENTRY_ADDR[11:2] == $past(I_MICROFRAME_COUNTER[12:3]))
    else $error("entry index wrong");
  aligned_addr_a: assert property (
    O_PERIODIC_ENTRY_ADDR[1:0] == 2'b00 && O_ASYNC_HEAD_ADDR[4:0] == 5'h00)
    else $error("fetch address misaligned");
endmodule
bind usb2_schedule_pointer_regs sched_ptr_checker #(.NUM_PORTS(NUM_PORTS)) i_sched_ptr_checker (.*);

/* sim/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) tests_run++; if ((a) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", n, e, a); end
module tb;
  import sched_ptr_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, wide = 0, flag, ack;
  logic [7:0] addr = 0;
  logic [3:0] be = 0;
  logic [3:0] lanes = 4'hf;
  logic [31:0] wd = 0, seg = 0, rdata, ex;
  logic [13:0] cnt = 0;
  logic [1:0] route;
  logic [63:0] pe, ah;
  frame_list_size_t frame_list_size_select = LIST_1024;
  int n_fail = 0, tests_run = 0, n;
  always #5 clk = ~clk;
  usb2_schedule_pointer_regs i_usb2_schedule_pointer_regs (.I_CLOCK(clk), .I_RST(rst),
    .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr),
    .I_REG_BE(be), .I_REG_WDATA(wd), .O_REG_RDATA(rdata), .O_REG_ACK(ack),
    .I_WIDE_ADDRESS_CAPABILITY(wide), .I_UPPER_ADDRESS_SEGMENT(seg), .I_MICROFRAME_COUNTER(cnt),
    .I_FRAME_LIST_SIZE_SELECT(frame_list_size_select), .O_PERIODIC_ENTRY_ADDR(pe), .O_ASYNC_HEAD_ADDR(ah),
    .O_PORT_OWNER_SELECT_FLAG(flag), .O_PORT_ROUTE_TO_HS(route));
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    be = lanes;
    wd = d;
    @(negedge clk);
    wr = 0;
    rd = 0;
    `CHK("ack", 1'b1, ack)
  endtask
  task automatic rd32(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK("rdata", e, rdata)
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    rd32(8'h34, 32'h0);
    rd32(8'h38, 32'h0);
    rd32(8'h60, 32'h0);
    $display("reset values done");
    // every write to a mapped register keeps reserved bits at zero, as software must
    acc(1'b1, 8'h34, 32'hffff_f000);
    rd32(8'h34, 32'hffff_f000);
    acc(1'b1, 8'h38, 32'habcd_e000);
    acc(1'b1, 8'h3c, 32'hffff_ffff);
    rd32(8'h38, 32'habcd_e000);
    rd32(8'h3c, 32'h0);
    lanes = 4'h2;
    acc(1'b1, 8'h60, 32'h0000_0001);
    lanes = 4'hf;
    rd32(8'h60, 32'h0);
    acc(1'b1, 8'h60, 32'h0000_0001);
    rd32(8'h60, 32'h1);
    `CHK("flag", 1'b1, flag)
    `CHK("route", 2'b11, route)
    acc(1'b1, 8'h60, 32'h0);
    `CHK("flag", 1'b0, flag)
    @(negedge clk);
    `CHK("route", 2'b00, route)
    $display("register access done");
    acc(1'b1, 8'h34, 32'h1234_5000);
    wide = 1;
    seg = 32'h0bad_0001;
    // bit 13 set so the 1024 case must drop it
    cnt = 14'h3ff9;
    for (int s = 0; s < 4; s++) begin
      frame_list_size_select = frame_list_size_t'(s);
      n = (s == 1) ? 11 : (s == 2) ? 10 : 12;
      ex = 32'h1234_5000 | (((32'(cnt) >> 3) & ((32'h1 << (n - 2)) - 1)) << 2);
      repeat (2) @(negedge clk);
      `CHK("entry", {seg, ex}, pe)
    end
    `CHK("async", {seg, 32'habcd_e000}, ah)
    wide = 0;
    repeat (2) @(negedge clk);
    `CHK("async", {32'h0, 32'habcd_e000}, ah)
    $display("fetch address done");
    lanes = 4'h8;
    acc(1'b1, 8'h34, 32'hab00_0000);
    lanes = 4'hf;
    rd32(8'h34, 32'hab34_5000);
    $display("byte lanes done");
    summarize;
  end
  initial begin
    // the sequence needs about fifty cycles, so this leaves ample margin
    #20000;
    n_fail++;
    summarize;
  end
endmodule
